// ==== exec_pkg.sv ====
// constants shared by the return/rotate/subtract execution block
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  localparam int PC_W = 10;
  localparam int NIB_TOP = 3;
  localparam int MSB = 7;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [9:0] PC_RST = 10'h000;
  localparam logic [1:0] RET_CYCLES = 2'h2;
  localparam logic [0:0] DEST_ACC = 1'h0;
  localparam logic [0:0] DEST_REG = 1'h1;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_RET,
    OP_RETURN_ENABLE_IRQ,
    OP_RETURN_WITH_LITERAL,
    OP_RLC,
    OP_RRC,
    OP_SBC_REG,
    OP_SBC_LIT
  } op_t;
endpackage : exec_pkg

// ==== return_rotate_subborrow_exec.sv ====
// execution of returns, rotates through carry and subtract-with-borrow
//
// Overview of operation
// - return_enable_irq reloads pc from stack top, sets global enable, two cycles
// - every return pops the return stack in the same cycle that pc takes the top entry
// - return_with_literal loads literal to accumulator, reloads pc, sets enable
// - subroutine_return reloads pc in two cycles, flags and enable untouched
// - rotate left: old carry into bit 0, bit 7 into carry, one cycle
// - rotate right: old carry into bit 7, bit 0 into carry, one cycle
// - destination bit zero writes accumulator, one writes the register back
// - register field is six bits, addressing file registers 0 to 63
// - register subtract: reg + ~acc + carry, routed by destination, flags
// - literal subtract: lit + ~acc + carry into accumulator, flags updated
`timescale 1ns/1ns
module return_rotate_subborrow_exec (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // instruction issue
  input wire logic issue_in,
  input wire exec_pkg::op_t op_in,
  input wire logic [exec_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic dest_in,
  input wire logic [exec_pkg::DATA_W-1:0] literal_in,
  // return stack
  input wire logic [exec_pkg::PC_W-1:0] stack_top_in,
  output logic stack_pop_out,
  // file register port
  output logic [exec_pkg::ADDR_W-1:0] file_addr_out,
  input wire logic [exec_pkg::DATA_W-1:0] file_rdata_in,
  output logic file_we_out,
  output logic [exec_pkg::DATA_W-1:0] file_wdata_out,
  // core state
  output logic busy_out,
  output logic [exec_pkg::PC_W-1:0] pc_out,
  output logic [exec_pkg::DATA_W-1:0] accumulator_out,
  output logic global_irq_enable_out,
  output logic zero_flag_out,
  output logic half_carry_flag_out,
  output logic carry_flag_out
);

  // ---------------------------------------------------------------
  // return sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_RET2} state_t;
  state_t state;
  state_t next_state;
  exec_pkg::op_t ret_op;

  wire take = issue_in && (state == S_IDLE);
  wire is_ret = (op_in == exec_pkg::OP_RET) ||
                (op_in == exec_pkg::OP_RETURN_ENABLE_IRQ) ||
                (op_in == exec_pkg::OP_RETURN_WITH_LITERAL);
  wire ret_start = take && is_ret;
  wire ret_finish = (state == S_RET2);

  always_comb begin
    case (state)
      S_IDLE: next_state = ret_start ? S_RET2 : S_IDLE;
      S_RET2: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // instructions offered while a return is in its second cycle are ignored
  assign busy_out = (state != S_IDLE);
  // pop in the second cycle, together with the pc load
  assign stack_pop_out = ret_finish;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= S_IDLE;
      ret_op <= exec_pkg::OP_NONE;
    end else begin
      state <= next_state;
      if (ret_start) begin
        ret_op <= op_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  assign file_addr_out = reg_addr_in;

  wire is_rlc = take && (op_in == exec_pkg::OP_RLC);
  wire is_rrc = take && (op_in == exec_pkg::OP_RRC);
  wire is_sbr = take && (op_in == exec_pkg::OP_SBC_REG);
  wire is_sbl = take && (op_in == exec_pkg::OP_SBC_LIT);
  wire is_rot = is_rlc || is_rrc;
  wire is_sbc = is_sbr || is_sbl;

  wire [7:0] rot_left = {file_rdata_in[exec_pkg::MSB-1:0], carry_flag_out};
  wire [7:0] rot_right = {carry_flag_out, file_rdata_in[exec_pkg::MSB:1]};

  wire [7:0] sbc_a = is_sbl ? literal_in : file_rdata_in;
  wire [7:0] sbc_sum;
  wire sbc_half;
  wire sbc_carry;

  // subtraction as a + ~acc + c, so carry set means no borrow
  sbc_adder u_adder (
    .a_in(sbc_a),
    .b_in(~accumulator_out),
    .c_in(carry_flag_out),
    .sum_out(sbc_sum),
    .half_out(sbc_half),
    .carry_out(sbc_carry)
  );

  wire [7:0] result = is_rlc ? rot_left :
                      is_rrc ? rot_right : sbc_sum;
  wire next_carry = is_rlc ? file_rdata_in[exec_pkg::MSB] :
                    is_rrc ? file_rdata_in[0] : sbc_carry;

  // literal subtract always lands in the accumulator
  wire to_reg = (is_rot || is_sbr) && (dest_in == exec_pkg::DEST_REG);
  wire to_acc = is_sbl || ((is_rot || is_sbr) &&
                (dest_in == exec_pkg::DEST_ACC));

  assign file_we_out = to_reg;
  assign file_wdata_out = result;

  wire lit_ret = ret_finish && (ret_op == exec_pkg::OP_RETURN_WITH_LITERAL);
  wire irq_ret = ret_finish && ((ret_op == exec_pkg::OP_RETURN_ENABLE_IRQ) ||
                 (ret_op == exec_pkg::OP_RETURN_WITH_LITERAL));

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_out <= exec_pkg::PC_RST;
    end else if (ret_finish) begin
      pc_out <= stack_top_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      accumulator_out <= exec_pkg::ACC_RST;
    end else if (lit_ret) begin
      accumulator_out <= literal_in;
    end else if (to_acc) begin
      accumulator_out <= result;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      global_irq_enable_out <= 1'b0;
    end else if (irq_ret) begin
      global_irq_enable_out <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      carry_flag_out <= 1'b0;
      half_carry_flag_out <= 1'b0;
      zero_flag_out <= 1'b0;
    end else begin
      if (is_rot || is_sbc) begin
        carry_flag_out <= next_carry;
      end
      if (is_sbc) begin
        half_carry_flag_out <= sbc_half;
        zero_flag_out <= (sbc_sum == 8'h00);
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_ret_issue;
    issue_in && !busy_out && (op_in == exec_pkg::OP_RETURN_ENABLE_IRQ);
  endsequence

  sequence s_lit_issue;
    issue_in && !busy_out && (op_in == exec_pkg::OP_RETURN_WITH_LITERAL);
  endsequence

  property p_return_enable_irq;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    s_ret_issue |=> stack_pop_out ##1
      (global_irq_enable_out && pc_out == $past(stack_top_in));
  endproperty
  a_return_enable_irq: assert property (p_return_enable_irq)
    else $error("interrupt return did not finish in two cycles");

  property p_pop;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    issue_in && !busy_out && is_ret |=> stack_pop_out ##1 !stack_pop_out;
  endproperty
  a_pop: assert property (p_pop)
    else $error("return did not pop exactly once");

  property p_return_with_literal;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    s_lit_issue |=> ##1 (accumulator_out == $past(literal_in) &&
      global_irq_enable_out);
  endproperty
  a_return_with_literal: assert property (p_return_with_literal)
    else $error("literal return failed to load accumulator");

  property p_ret;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    issue_in && !busy_out && (op_in == exec_pkg::OP_RET) |=> ##1
      ($stable(global_irq_enable_out) && $stable(carry_flag_out) &&
       $stable(zero_flag_out) && pc_out == $past(stack_top_in));
  endproperty
  a_ret: assert property (p_ret)
    else $error("plain return altered state or missed pc");

  property p_rlc;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_rlc |=> carry_flag_out == $past(file_rdata_in[7]) &&
      $stable(zero_flag_out);
  endproperty
  a_rlc: assert property (p_rlc)
    else $error("rotate left carry wrong");

  property p_rrc;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_rrc |-> file_wdata_out[7] == carry_flag_out ##1
      carry_flag_out == $past(file_rdata_in[0]);
  endproperty
  a_rrc: assert property (p_rrc)
    else $error("rotate right carry wrong");

  property p_dest;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (is_rot || is_sbr) && dest_in |-> file_we_out ##1
      $stable(accumulator_out);
  endproperty
  a_dest: assert property (p_dest)
    else $error("register destination touched accumulator");

  property p_sbl;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_sbl |-> !file_we_out ##1 accumulator_out ==
      8'($past(literal_in) + ~$past(accumulator_out) +
      {7'h00, $past(carry_flag_out)});
  endproperty
  a_sbl: assert property (p_sbl)
    else $error("literal subtract result wrong");

  property p_flags;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_sbr |=> zero_flag_out == ($past(sbc_sum) == 8'h00) &&
      carry_flag_out == $past(sbc_carry);
  endproperty
  a_flags: assert property (p_flags)
    else $error("subtract flags wrong");

  sequence s_any_ret;
    issue_in && !busy_out && is_ret;
  endsequence

  property p_busy_one;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    s_any_ret |=> busy_out ##1 !busy_out;
  endproperty
  a_busy_one: assert property (p_busy_one)
    else $error("return did not hold busy for exactly one cycle");

  property p_ret_flags;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    s_any_ret |=> ($stable(carry_flag_out) && $stable(zero_flag_out)) ##1
      ($stable(carry_flag_out) && $stable(half_carry_flag_out));
  endproperty
  a_ret_flags: assert property (p_ret_flags)
    else $error("return altered a status flag");

  property p_pc_hold;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !stack_pop_out |=> $stable(pc_out);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("pc moved outside a return");

  property p_ie_hold;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !stack_pop_out |=> $stable(global_irq_enable_out);
  endproperty
  a_ie_hold: assert property (p_ie_hold)
    else $error("interrupt enable moved outside a return");

  // an instruction offered in the busy cycle must leave no trace
  property p_ignore;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    busy_out && issue_in |-> !file_we_out ##1 $stable(carry_flag_out);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("instruction taken while busy");

  property p_rlc_data;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_rlc |-> file_wdata_out == {file_rdata_in[6:0], carry_flag_out};
  endproperty
  a_rlc_data: assert property (p_rlc_data)
    else $error("rotate left result wrong");

  property p_rrc_data;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_rrc |-> file_wdata_out == {carry_flag_out, file_rdata_in[7:1]};
  endproperty
  a_rrc_data: assert property (p_rrc_data)
    else $error("rotate right result wrong");

  property p_rot_only_carry;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_rot |=> $stable(zero_flag_out) && $stable(half_carry_flag_out);
  endproperty
  a_rot_only_carry: assert property (p_rot_only_carry)
    else $error("rotate changed a flag other than carry");

  property p_acc_dest;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (is_rot || is_sbr) && !dest_in |-> !file_we_out;
  endproperty
  a_acc_dest: assert property (p_acc_dest)
    else $error("accumulator destination wrote the register");

  property p_rot_acc;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_rot && !dest_in |=> accumulator_out == $past(file_wdata_out);
  endproperty
  a_rot_acc: assert property (p_rot_acc)
    else $error("rotate result missed the accumulator");

  property p_sbr_value;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_sbr |-> file_wdata_out ==
      8'(file_rdata_in + ~accumulator_out + {7'h00, carry_flag_out});
  endproperty
  a_sbr_value: assert property (p_sbr_value)
    else $error("register subtract result wrong");

  property p_sbl_half;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_sbl |=> half_carry_flag_out == (({1'b0, $past(literal_in[3:0])} +
      {1'b0, ~$past(accumulator_out[3:0])} +
      {4'h0, $past(carry_flag_out)}) > 5'h0F);
  endproperty
  a_sbl_half: assert property (p_sbl_half)
    else $error("literal subtract half carry wrong");

  property p_sbl_zero;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    is_sbl |=> zero_flag_out == (accumulator_out == 8'h00);
  endproperty
  a_sbl_zero: assert property (p_sbl_zero)
    else $error("literal subtract zero flag wrong");

endmodule : return_rotate_subborrow_exec

// ==== return_rotate_subborrow_exec_tb.sv ====
// self-checking bench for the return, rotate and subtract block
`timescale 1ns/1ns
module return_rotate_subborrow_exec_tb;
  // ------------------
  // signals and model
  // ------------------
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic issue_in = 1'b0;
  exec_pkg::op_t op_in = exec_pkg::OP_NONE;
  logic [5:0] reg_addr_in = 6'h00;
  logic dest_in = 1'b0;
  logic [7:0] literal_in = 8'h00;
  logic [9:0] stack_top_in = 10'h000;
  logic pop, we, busy, ie, zf, hf, cf;
  logic [5:0] fa;
  logic [7:0] rd, wd, accum;
  logic [9:0] pc;
  logic [7:0] regs [64];
  logic [7:0] m_accum;
  logic [9:0] m_pc;
  logic m_c, m_z, m_hc, m_ie;
  int failures = 0;
  int checks_done = 0;

  return_rotate_subborrow_exec DUT (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .issue_in(issue_in),
    .op_in(op_in), .reg_addr_in(reg_addr_in), .dest_in(dest_in),
    .literal_in(literal_in), .stack_top_in(stack_top_in),
    .stack_pop_out(pop), .file_addr_out(fa), .file_rdata_in(rd),
    .file_we_out(we), .file_wdata_out(wd), .busy_out(busy),
    .pc_out(pc), .accumulator_out(accum), .global_irq_enable_out(ie),
    .zero_flag_out(zf), .half_carry_flag_out(hf), .carry_flag_out(cf));

  initial forever #2 ref_clk_in = ~ref_clk_in;
  // file registers answer in the same cycle, as the core expects
  assign rd = regs[fa];
  always @(posedge ref_clk_in) if (we === 1'b1) regs[fa] <= wd;

  // ------------------
  // shared tasks
  // ------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_state;
    check(pc, m_pc);
    check(accum, m_accum);
    check(ie, m_ie);
    check(zf, m_z);
    check(hf, m_hc);
    check(cf, m_c);
  endtask : check_state

  task automatic apply_reset;
    @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    {m_accum, m_pc, m_c, m_z, m_hc, m_ie} = '0;
    #1;
    check_state();
    check(busy, 1'b0);
  endtask : apply_reset

  task automatic run1(input exec_pkg::op_t op, input logic [5:0] a,
                      input logic d, input logic [7:0] lit);
    logic [7:0] src;
    logic [8:0] sum;
    logic hc;
    logic to_reg;
    @(posedge ref_clk_in);
    issue_in <= 1'b1;
    op_in <= op;
    reg_addr_in <= a;
    dest_in <= d;
    literal_in <= lit;
    #1;
    src = (op == exec_pkg::OP_SBC_LIT) ? lit : regs[a];
    sum = {1'b0, src} + {1'b0, ~m_accum} + m_c;
    hc = ({1'b0, src[3:0]} + {1'b0, ~m_accum[3:0]} + m_c) > 5'h0F;
    if (op == exec_pkg::OP_RLC) sum = {src, m_c};
    if (op == exec_pkg::OP_RRC) sum = {src[0], m_c, src[7:1]};
    to_reg = d && (op != exec_pkg::OP_SBC_LIT);
    check(fa, a);
    check(we, to_reg);
    if (to_reg) check(wd, sum[7:0]);
    @(posedge ref_clk_in);
    issue_in <= 1'b0;
    #1;
    if (op == exec_pkg::OP_SBC_REG || op == exec_pkg::OP_SBC_LIT) begin
      m_z = (sum[7:0] == 8'h00);
      m_hc = hc;
    end
    m_c = sum[8];
    if (!to_reg) m_accum = sum[7:0];
    if (to_reg) check(regs[a], sum[7:0]);
    check_state();
  endtask : run1

  task automatic ret_op(input exec_pkg::op_t op, input logic [7:0] lit,
                        input logic [9:0] top);
    @(posedge ref_clk_in);
    issue_in <= 1'b1;
    op_in <= op;
    literal_in <= lit;
    stack_top_in <= top;
    @(posedge ref_clk_in);
    // a rotate offered while busy must be dropped
    op_in <= exec_pkg::OP_RLC;
    reg_addr_in <= 6'h3F;
    dest_in <= 1'b1;
    #1;
    check(busy, 1'b1);
    check(pop, 1'b1);
    check(we, 1'b0);
    @(posedge ref_clk_in);
    issue_in <= 1'b0;
    #1;
    m_pc = top;
    if (op != exec_pkg::OP_RET) m_ie = 1'b1;
    if (op == exec_pkg::OP_RETURN_WITH_LITERAL) m_accum = lit;
    check(busy, 1'b0);
    check(pop, 1'b0);
    check_state();
  endtask : ret_op

  // ------------------
  // scenarios
  // ------------------
  task automatic test_returns;
    ret_op(exec_pkg::OP_RET, 8'h3C, 10'h2A5);
    ret_op(exec_pkg::OP_RETURN_WITH_LITERAL, 8'h06, 10'h3FF);
    apply_reset();
    ret_op(exec_pkg::OP_RETURN_ENABLE_IRQ, 8'h11, 10'h155);
    $display("test returns done");
  endtask : test_returns

  task automatic test_rotate;
    run1(exec_pkg::OP_RLC, 6'h05, 1'b1, 8'h00);
    run1(exec_pkg::OP_RRC, 6'h3F, 1'b0, 8'h00);
    run1(exec_pkg::OP_RRC, 6'h05, 1'b1, 8'h00);
    run1(exec_pkg::OP_RLC, 6'h00, 1'b0, 8'h00);
    $display("test rotate done");
  endtask : test_rotate

  task automatic test_subtract;
    run1(exec_pkg::OP_SBC_REG, 6'h3F, 1'b1, 8'h00);
    run1(exec_pkg::OP_SBC_REG, 6'h05, 1'b0, 8'h00);
    run1(exec_pkg::OP_SBC_LIT, 6'h05, 1'b1, 8'h05);
    // literal chosen so the result is exactly zero
    run1(exec_pkg::OP_SBC_LIT, 6'h00, 1'b0, m_accum + 8'h01 - m_c);
    run1(exec_pkg::OP_SBC_LIT, 6'h00, 1'b0, 8'hFF);
    $display("test subtract done");
  endtask : test_subtract

  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial begin
    for (int i = 0; i < 64; i++) regs[i] = 8'(i * 29 + 5);
    regs[5] = 8'hA5;
    apply_reset();
    test_returns();
    test_rotate();
    test_subtract();
    finish_test();
  end

  initial begin
    #20000;
    failures++;
    finish_test();
  end
endmodule : return_rotate_subborrow_exec_tb

// ==== sbc_adder.sv ====
// 8-bit add with carry-in, reporting nibble and byte carries
`timescale 1ns/1ns
module sbc_adder (
  // operands
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic c_in,
  // results
  output logic [7:0] sum_out,
  output logic half_out,
  output logic carry_out
);
  wire [4:0] low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, c_in};
  wire [4:0] high = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, low[4]};
  assign sum_out = {high[3:0], low[3:0]};
  assign half_out = low[4];
  assign carry_out = high[4];
endmodule : sbc_adder
